/* gpl_cfg.svh */
// constants of the general purpose port block: sfr offsets, reset values, bit ranges
// assumes one 8-bit special function register space shared with the cpu core
`ifndef GPL_CFG_SVH
`define GPL_CFG_SVH

// ==========================================================
// register offsets
`define GPL_OFS_P0      8'h80
`define GPL_OFS_P1      8'h90
`define GPL_OFS_P2      8'ha0
`define GPL_OFS_MDOUT   8'ha4
`define GPL_OFS_SKIP1   8'hd5
`define GPL_OFS_MDIN    8'hf1

// ==========================================================
// reset values
`define GPL_RST_P0      8'hff
`define GPL_RST_P1      8'hff
`define GPL_RST_P2      8'h01
`define GPL_RST_MDOUT   8'h00
`define GPL_RST_SKIP1   8'h00
`define GPL_RST_MDIN    8'hff

// ==========================================================
// field layout
`define GPL_P2_LIVE     8'h01
`define GPL_SKIP1_LIVE  8'h7f
`define GPL_BIT_IDX_W   3

`endif

/* gpl_pkg.sv */
// types shared by the general purpose port block
// assumes gpl_cfg.svh is on the include path
package gpl_pkg;

	typedef logic [7:0] gpl_byte_t;

	// register targeted by a byte or bit access
	typedef enum logic [2:0] {
		GPL_SEL_NONE,
		GPL_SEL_P0,
		GPL_SEL_P1,
		GPL_SEL_P2,
		GPL_SEL_MDOUT,
		GPL_SEL_SKIP1,
		GPL_SEL_MDIN
	} gpl_sel_t;

endpackage

/* gpl_port_latch.sv */
// general purpose port latches, pin read path and output drivers for ports 0..2
// assumes the cpu core gives one-cycle sfr strobes on clk and flags read-modify-write cycles
`timescale 1ns/10ps
`include "gpl_cfg.svh"

module gpl_port_latch
	import gpl_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              sfr_wr,
	input  wire logic              sfr_rd,
	input  wire logic [7:0]        sfr_addr,
	input  wire logic [7:0]        sfr_wdata,
	input  wire logic              sfr_bit_wr,
	input  wire logic              sfr_bit_rd,
	input  wire logic [7:0]        sfr_bit_addr,
	input  wire logic              sfr_bit_wdata,
	input  wire logic              sfr_rmw,
	output logic [7:0]             sfr_rdata_q,
	output logic                   sfr_bit_rdata_q,
	input  wire logic              crossbar_enable_bit,
	input  wire logic [PORT_W-1:0] xbar_claim0,
	input  wire logic [PORT_W-1:0] xbar_out0,
	input  wire logic [PORT_W-1:0] xbar_claim1,
	input  wire logic [PORT_W-1:0] xbar_out1,
	input  wire logic              xbar_claim2,
	input  wire logic              xbar_out2,
	input  wire logic [PORT_W-1:0] p0_pin_in,
	output logic [PORT_W-1:0]      p0_pin_out_q,
	output logic [PORT_W-1:0]      p0_pin_oe_q,
	input  wire logic [PORT_W-1:0] p1_pin_in,
	output logic [PORT_W-1:0]      p1_pin_out_q,
	output logic [PORT_W-1:0]      p1_pin_oe_q,
	input  wire logic              p2_pin_in,
	output logic                   p2_pin_out_q,
	output logic                   p2_pin_oe_q,
	output logic [7:0]             port_one_crossbar_bypass_q
);

	if (PORT_W != 8) begin : g_chk
		$error("gpl_port_latch serves byte-wide ports only");
	end

	// ==========================================================
	// decode helpers
	function automatic gpl_sel_t sel_of(input logic [7:0] a);
		case (a)
			`GPL_OFS_P0:    sel_of = GPL_SEL_P0;
			`GPL_OFS_P1:    sel_of = GPL_SEL_P1;
			`GPL_OFS_P2:    sel_of = GPL_SEL_P2;
			`GPL_OFS_MDOUT: sel_of = GPL_SEL_MDOUT;
			`GPL_OFS_SKIP1: sel_of = GPL_SEL_SKIP1;
			`GPL_OFS_MDIN:  sel_of = GPL_SEL_MDIN;
			default:        sel_of = GPL_SEL_NONE;
		endcase
	endfunction

	// next value of a latch under byte write, bit write or hold
	function automatic gpl_byte_t next_of(input gpl_byte_t cur, input logic bw,
			input logic bitw, input logic [2:0] idx, input logic val, input gpl_byte_t wd);
		gpl_byte_t r;
		r = cur;
		if (bw) begin
			r = wd;
		end else if (bitw) begin
			r[idx] = val;
		end
		next_of = r;
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [7:0] p0_s1_q, p0_s2_q, p1_s1_q, p1_s2_q;
	logic       p2_s1_q, p2_s2_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			p0_s1_q <= 8'h00;
			p0_s2_q <= 8'h00;
			p1_s1_q <= 8'h00;
			p1_s2_q <= 8'h00;
			p2_s1_q <= 1'b0;
			p2_s2_q <= 1'b0;
		end else begin
			p0_s1_q <= p0_pin_in;
			p0_s2_q <= p0_s1_q;
			p1_s1_q <= p1_pin_in;
			p1_s2_q <= p1_s1_q;
			p2_s1_q <= p2_pin_in;
			p2_s2_q <= p2_s1_q;
		end
	end

	// ==========================================================
	// access decode
	gpl_sel_t   byte_sel, bit_sel;
	logic [2:0] bit_idx;
	wire logic  [7:0] bit_base = {sfr_bit_addr[7:3], 3'h0};

	assign byte_sel = sel_of(sfr_addr);
	assign bit_sel  = sel_of(bit_base);
	assign bit_idx  = sfr_bit_addr[`GPL_BIT_IDX_W-1:0];

	// only ports are bit addressable; mode registers take byte access only
	wire logic bw_p0 = sfr_wr && byte_sel == GPL_SEL_P0;
	wire logic bw_p1 = sfr_wr && byte_sel == GPL_SEL_P1;
	wire logic bw_p2 = sfr_wr && byte_sel == GPL_SEL_P2;
	wire logic bt_p0 = sfr_bit_wr && bit_sel == GPL_SEL_P0;
	wire logic bt_p1 = sfr_bit_wr && bit_sel == GPL_SEL_P1;
	wire logic bt_p2 = sfr_bit_wr && bit_sel == GPL_SEL_P2;

	// ==========================================================
	// output latches and mode registers
	gpl_byte_t p0_q, p1_q, p2_q, mdout_q, mdin_q;
	gpl_byte_t p0_d, p1_d, p2_d;

	assign p0_d = next_of(p0_q, bw_p0, bt_p0, bit_idx, sfr_bit_wdata, sfr_wdata);
	assign p1_d = next_of(p1_q, bw_p1, bt_p1, bit_idx, sfr_bit_wdata, sfr_wdata);
	assign p2_d = next_of(p2_q, bw_p2, bt_p2, bit_idx, sfr_bit_wdata, sfr_wdata)
		& `GPL_P2_LIVE;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			p0_q <= `GPL_RST_P0;
			p1_q <= `GPL_RST_P1;
			p2_q <= `GPL_RST_P2;
		end else begin
			p0_q <= p0_d;
			p1_q <= p1_d;
			p2_q <= p2_d;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mdout_q                    <= `GPL_RST_MDOUT;
			mdin_q                     <= `GPL_RST_MDIN;
			port_one_crossbar_bypass_q <= `GPL_RST_SKIP1;
		end else if (sfr_wr) begin
			if (byte_sel == GPL_SEL_MDOUT) begin
				mdout_q <= sfr_wdata;
			end
			if (byte_sel == GPL_SEL_MDIN) begin
				mdin_q <= sfr_wdata;
			end
			if (byte_sel == GPL_SEL_SKIP1) begin
				port_one_crossbar_bypass_q <= sfr_wdata & `GPL_SKIP1_LIVE;
			end
		end
	end

	// ==========================================================
	// read path
	// analog-configured port 0 pins read as zero; port 2 has a single pin
	gpl_byte_t p0_pins, p1_pins, p2_pins;
	assign p0_pins = p0_s2_q & mdin_q;
	assign p1_pins = p1_s2_q;
	assign p2_pins = {7'h00, p2_s2_q};

	function automatic gpl_byte_t read_of(input gpl_sel_t s, input logic rmw,
			input gpl_byte_t l0, input gpl_byte_t l1, input gpl_byte_t l2,
			input gpl_byte_t i0, input gpl_byte_t i1, input gpl_byte_t i2,
			input gpl_byte_t md, input gpl_byte_t mi, input gpl_byte_t sk);
		case (s)
			GPL_SEL_P0:    read_of = rmw ? l0 : i0;
			GPL_SEL_P1:    read_of = rmw ? l1 : i1;
			GPL_SEL_P2:    read_of = rmw ? l2 : i2;
			GPL_SEL_MDOUT: read_of = md;
			GPL_SEL_MDIN:  read_of = mi;
			GPL_SEL_SKIP1: read_of = sk;
			default:       read_of = 8'h00;
		endcase
	endfunction

	// the core flags and/or/xor, jbc, cpl, inc, dec, djnz and bit mov/clr/setb as rmw
	gpl_byte_t byte_rd_val, bit_rd_byte;
	assign byte_rd_val = read_of(byte_sel, sfr_rmw, p0_q, p1_q, p2_q, p0_pins, p1_pins,
		p2_pins, mdout_q, mdin_q, port_one_crossbar_bypass_q);
	assign bit_rd_byte = read_of(bit_sel, sfr_rmw, p0_q, p1_q, p2_q, p0_pins, p1_pins,
		p2_pins, mdout_q, mdin_q, port_one_crossbar_bypass_q);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata_q     <= 8'h00;
			sfr_bit_rdata_q <= 1'b0;
		end else begin
			if (sfr_rd) begin
				sfr_rdata_q <= byte_rd_val;
			end
			if (sfr_bit_rd) begin
				sfr_bit_rdata_q <= bit_rd_byte[bit_idx];
			end
		end
	end

	// ==========================================================
	// output drivers
	// crossbar-claimed pins take the peripheral level; the rest take the latch
	gpl_byte_t p0_val, p1_val;
	logic      p2_val;
	assign p0_val = (xbar_claim0 & xbar_out0) | (~xbar_claim0 & p0_q);
	assign p1_val = (xbar_claim1 & xbar_out1) | (~xbar_claim1 & p1_q);
	assign p2_val = xbar_claim2 ? xbar_out2 : p2_q[0];

	// ports 1 and 2 carry no drive mode register here, so they stay open-drain
	gpl_byte_t p0_oe_d, p1_oe_d;
	logic      p2_oe_d;
	assign p0_oe_d = {8{crossbar_enable_bit}} & mdin_q & (mdout_q | ~p0_val);
	assign p1_oe_d = {8{crossbar_enable_bit}} & ~p1_val;
	assign p2_oe_d = crossbar_enable_bit & ~p2_val;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			p0_pin_out_q <= 8'h00;
			p0_pin_oe_q  <= 8'h00;
			p1_pin_out_q <= 8'h00;
			p1_pin_oe_q  <= 8'h00;
			p2_pin_out_q <= 1'b0;
			p2_pin_oe_q  <= 1'b0;
		end else begin
			p0_pin_out_q <= p0_val;
			p0_pin_oe_q  <= p0_oe_d;
			p1_pin_out_q <= p1_val;
			p1_pin_oe_q  <= p1_oe_d;
			p2_pin_out_q <= p2_val;
			p2_pin_oe_q  <= p2_oe_d;
		end
	end

	// ==========================================================
	// assertions
	property p_byte_write_latches;
		@(posedge clk) disable iff (!rstn)
		(sfr_wr && sfr_addr == `GPL_OFS_P0) |=> (p0_q == $past(sfr_wdata));
	endproperty
	a_byte_write_latches: assert property (p_byte_write_latches)
		else $error("port 0 latch missed a byte write");

	property p_latch_holds;
		@(posedge clk) disable iff (!rstn)
		(!bw_p0 && !bt_p0) |=> $stable(p0_q);
	endproperty
	a_latch_holds: assert property (p_latch_holds)
		else $error("port 0 latch changed without a write");

	property p_bit_write_one_bit;
		@(posedge clk) disable iff (!rstn)
		(bt_p0 && !bw_p0) |=> (p0_q[$past(bit_idx)] == $past(sfr_bit_wdata))
			&& ((p0_q ^ $past(p0_q)) & ~(8'h01 << $past(bit_idx))) == 8'h00;
	endproperty
	a_bit_write_one_bit: assert property (p_bit_write_one_bit)
		else $error("bit write disturbed other port bits");

	property p_plain_read_pins;
		@(posedge clk) disable iff (!rstn)
		(sfr_rd && !sfr_rmw && sfr_addr == `GPL_OFS_P1) |=> sfr_rdata_q == $past(p1_s1_q, 2);
	endproperty
	a_plain_read_pins: assert property (p_plain_read_pins)
		else $error("plain port read did not return pin levels");

	property p_rmw_read_latch;
		@(posedge clk) disable iff (!rstn)
		(sfr_rd && sfr_rmw && sfr_addr == `GPL_OFS_P0) |=> sfr_rdata_q == $past(p0_q);
	endproperty
	a_rmw_read_latch: assert property (p_rmw_read_latch)
		else $error("read-modify-write read did not return latch");

	property p_rmw_bit_latch;
		@(posedge clk) disable iff (!rstn)
		(sfr_bit_rd && sfr_rmw && bit_sel == GPL_SEL_P1)
			|=> sfr_bit_rdata_q == $past(p1_q[bit_idx]);
	endproperty
	a_rmw_bit_latch: assert property (p_rmw_bit_latch)
		else $error("bit read-modify-write did not read latch");

	property p_xbar_off_no_drive;
		@(posedge clk) disable iff (!rstn)
		!crossbar_enable_bit |=> p0_pin_oe_q == 8'h00 && p1_pin_oe_q == 8'h00 && !p2_pin_oe_q;
	endproperty
	a_xbar_off_no_drive: assert property (p_xbar_off_no_drive)
		else $error("driver enabled while crossbar disabled");

	property p_push_pull;
		@(posedge clk) disable iff (!rstn)
		(crossbar_enable_bit && mdout_q[0] && mdin_q[0]) |=> p0_pin_oe_q[0];
	endproperty
	a_push_pull: assert property (p_push_pull)
		else $error("push-pull pin not driven");

	property p_open_drain_high;
		@(posedge clk) disable iff (!rstn)
		(!mdout_q[0] && !xbar_claim0[0] && p0_q[0]) |=> !p0_pin_oe_q[0];
	endproperty
	a_open_drain_high: assert property (p_open_drain_high)
		else $error("open-drain pin drove a high level");

	property p_gpio_out;
		@(posedge clk) disable iff (!rstn)
		(!xbar_claim1[3]) |=> p1_pin_out_q[3] == $past(p1_q[3]);
	endproperty
	a_gpio_out: assert property (p_gpio_out)
		else $error("unclaimed pin does not follow latch");

	cover property (@(posedge clk) disable iff (!rstn) bw_p0 ##1 sfr_rd && sfr_rmw);
	cover property (@(posedge clk) disable iff (!rstn) bt_p2 ##1 sfr_bit_rd);
	cover property (@(posedge clk) disable iff (!rstn)
		crossbar_enable_bit && (p0_oe_d != 8'h00) ##1 !crossbar_enable_bit);

endmodule

/* gpl_pin_model.sv */
// external circuitry on the port pins: weak pull-ups plus an optional external driver
// assumes open-drain style wiring, so any party driving low wins
`timescale 1ns/10ps

module gpl_pin_model #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] out,
	input  wire logic [W-1:0] ext_en,
	input  wire logic [W-1:0] ext_val,
	output logic [W-1:0]      pin
);
	// ==========================================================
	// wire resolution
	// a released pin floats to the pull-up level, never to the last driven value
	assign pin = (~oe | out) & (~ext_en | ext_val);
endmodule

/* gpl_port_latch_test.sv */
// testbench of the general purpose port latches, driven through sfr byte and bit cycles
// assumes gpl_pin_model closes each pin, inputs change on the falling clock edge
`timescale 1ns/10ps
`include "gpl_cfg.svh"

module gpl_port_latch_test;
	import gpl_pkg::*;
	logic       clk, rstn, wr, rd, bwr, brd, bwd, rmw, xen, claim2, xo2, e2, v2;
	logic [7:0] addr, wd, baddr, claim0, xo0, claim1, xo1, e0, v0, e1, v1, rdat, bp;
	logic [7:0] p0i, p0o, p0e, p1i, p1o, p1e, cur;
	logic       p2i, p2o, p2e, brdat;
	int         err_count, comparisons;

	gpl_port_latch i_dut (.clk(clk), .rstn(rstn), .sfr_wr(wr), .sfr_rd(rd), .sfr_addr(addr),
		.sfr_wdata(wd), .sfr_bit_wr(bwr), .sfr_bit_rd(brd), .sfr_bit_addr(baddr),
		.sfr_bit_wdata(bwd), .sfr_rmw(rmw), .sfr_rdata_q(rdat), .sfr_bit_rdata_q(brdat),
		.crossbar_enable_bit(xen), .xbar_claim0(claim0), .xbar_out0(xo0),
		.xbar_claim1(claim1), .xbar_out1(xo1), .xbar_claim2(claim2), .xbar_out2(xo2),
		.p0_pin_in(p0i), .p0_pin_out_q(p0o), .p0_pin_oe_q(p0e), .p1_pin_in(p1i),
		.p1_pin_out_q(p1o), .p1_pin_oe_q(p1e), .p2_pin_in(p2i), .p2_pin_out_q(p2o),
		.p2_pin_oe_q(p2e), .port_one_crossbar_bypass_q(bp));
	gpl_pin_model #(.W(8)) i_pins0 (.oe(p0e), .out(p0o), .ext_en(e0), .ext_val(v0), .pin(p0i));
	gpl_pin_model #(.W(8)) i_pins1 (.oe(p1e), .out(p1o), .ext_en(e1), .ext_val(v1), .pin(p1i));
	gpl_pin_model #(.W(1)) i_pins2 (.oe(p2e), .out(p2o), .ext_en(e2), .ext_val(v2), .pin(p2i));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// access tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask
	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{wr, addr, wd} = {1'b1, a, d};
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_b(input logic [7:0] a, input logic m, input logic [7:0] e);
		@(negedge clk);
		{rd, addr, rmw} = {1'b1, a, m};
		@(negedge clk);
		{rd, rmw} = 2'b00;
		chk($sformatf("byte %h", a), e, rdat);
	endtask
	task automatic wr_bit(input logic [7:0] a, input logic d);
		@(negedge clk);
		{bwr, baddr, bwd} = {1'b1, a, d};
		@(negedge clk);
		bwr = 1'b0;
	endtask
	task automatic rd_bit(input logic [7:0] a, input logic m, input logic e);
		@(negedge clk);
		{brd, baddr, rmw} = {1'b1, a, m};
		@(negedge clk);
		{brd, rmw} = 2'b00;
		chk($sformatf("bit %h", a), {7'h00, e}, {7'h00, brdat});
	endtask
	task automatic settle();
		repeat (4) @(negedge clk);
	endtask
	function automatic logic [7:0] rmw_op(input int k, input logic [7:0] v);
		case (k)
			0: return v & 8'h0f;
			1: return v | 8'h30;
			2: return v ^ 8'hff;
			3: return v + 8'h01;
			4: return v - 8'h01;
			default: return ~v;
		endcase
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#50us;
		err_count++;
		give_verdict();
	end

	// ==========================================================
	// test sequence
	initial begin
		{wr, rd, bwr, brd, bwd, rmw, xen, claim2, xo2, e2, v2} = '0;
		{addr, wd, baddr, claim0, xo0, claim1, xo1, e0, v0, e1, v1} = '0;
		err_count = 0;
		comparisons = 0;
		rstn = 1'b0;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		rd_b(`GPL_OFS_P0, 1'b1, `GPL_RST_P0);
		rd_b(`GPL_OFS_P2, 1'b1, `GPL_RST_P2);
		rd_b(`GPL_OFS_MDOUT, 1'b0, `GPL_RST_MDOUT);
		rd_b(`GPL_OFS_MDIN, 1'b0, `GPL_RST_MDIN);
		rd_b(`GPL_OFS_SKIP1, 1'b0, `GPL_RST_SKIP1);
		wr_b(8'h33, 8'h5a);
		rd_b(8'h33, 1'b0, 8'h00);
		wr_b(`GPL_OFS_SKIP1, 8'hff);
		rd_b(`GPL_OFS_SKIP1, 1'b0, 8'h7f);
		chk("bypass", 8'h7f, bp);
		$display("test reset values done");
		xen = 1'b1;
		wr_b(`GPL_OFS_P0, 8'h5a);
		rd_b(`GPL_OFS_P0, 1'b1, 8'h5a);
		settle();
		chk("p0 out", 8'h5a, p0o);
		chk("p0 oe open drain", 8'ha5, p0e);
		wr_b(`GPL_OFS_MDOUT, 8'hff);
		settle();
		chk("p0 oe push pull", 8'hff, p0e);
		wr_b(`GPL_OFS_MDOUT, 8'h00);
		wr_b(`GPL_OFS_P2, 8'hff);
		rd_b(`GPL_OFS_P2, 1'b1, 8'h01);
		wr_b(`GPL_OFS_P2, 8'h00);
		settle();
		chk("p2 oe", 8'h01, {7'h00, p2e});
		chk("p2 out", 8'h00, {7'h00, p2o});
		$display("test output latch done");
		{e1, v1} = {8'hff, 8'h3c};
		settle();
		chk("p1 out", 8'hff, p1o);
		chk("p1 oe", 8'h00, p1e);
		rd_b(`GPL_OFS_P1, 1'b0, 8'h3c);
		{v1, claim1, xo1} = {8'hff, 8'h01, 8'h00};
		{claim2, xo2} = 2'b11;
		settle();
		chk("p1 claimed out", 8'hfe, p1o);
		chk("p1 claimed oe", 8'h01, p1e);
		chk("p2 claimed out", 8'h01, {7'h00, p2o});
		chk("p2 claimed oe", 8'h00, {7'h00, p2e});
		rd_b(`GPL_OFS_P1, 1'b0, 8'hfe);
		rd_bit(`GPL_OFS_P2, 1'b0, 1'b1);
		rd_bit(`GPL_OFS_P2, 1'b1, 1'b0);
		{claim1, claim2, xo2} = '0;
		xen = 1'b0;
		settle();
		chk("p0 oe disabled", 8'h00, p0e);
		chk("p1 oe disabled", 8'h00, p1e);
		chk("p2 oe disabled", 8'h00, {7'h00, p2e});
		$display("test pin reads done");
		{e0, v0} = {8'h01, 8'h00};
		wr_bit(`GPL_OFS_P0 | 8'h00, 1'b1);
		settle();
		rd_bit(`GPL_OFS_P0 | 8'h00, 1'b0, 1'b0);
		rd_bit(`GPL_OFS_P0 | 8'h00, 1'b1, 1'b1);
		rd_b(`GPL_OFS_P0, 1'b1, 8'h5b);
		e0 = 8'h00;
		wr_b(`GPL_OFS_MDIN, 8'hfe);
		settle();
		rd_b(`GPL_OFS_P0, 1'b0, 8'hfe);
		$display("test bit access done");
		{e1, v1} = {8'hff, 8'h00};
		cur = `GPL_RST_P1;
		for (int k = 0; k < 6; k++) begin
			rd_b(`GPL_OFS_P1, 1'b1, cur);
			cur = rmw_op(k, cur);
			wr_b(`GPL_OFS_P1, cur);
		end
		rd_b(`GPL_OFS_P1, 1'b1, cur);
		rd_bit(`GPL_OFS_P1 | 8'h03, 1'b1, 1'b1);
		rd_bit(`GPL_OFS_P1 | 8'h03, 1'b0, 1'b0);
		$display("test read modify write done");
		// a second reset mid-run must bring the port 1 and port 0 latches back to their reset values
		rstn = 1'b0;
		repeat (3) @(negedge clk);
		chk("p1 oe in reset", 8'h00, p1e);
		rstn = 1'b1;
		rd_b(`GPL_OFS_P1, 1'b1, `GPL_RST_P1);
		rd_b(`GPL_OFS_P0, 1'b1, `GPL_RST_P0);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule
